// ==== common/sebs_consts.svh ====
// named constants of the servo enable and brake sequencer
// assumes a 20 MHz aclk and an AXI4-Lite master with 32-bit data
`ifndef SEBS_CONSTS_SVH
`define SEBS_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SEBS_CLK_NS          50
`define SEBS_MS_NS           1000000
`define SEBS_READY_MS        1500
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SEBS_OFS_THR_STILL   8'h00
`define SEBS_OFS_DLY_STILL   8'h04
`define SEBS_OFS_WAIT_RUN    8'h08
`define SEBS_OFS_SPD_RUN     8'h0C
`define SEBS_OFS_DLY_REL     8'h10
`define SEBS_OFS_STATUS      8'h14
// ----------------------------------------
// register indexes
// ----------------------------------------
`define SEBS_IDX_THR_STILL   3'h0
`define SEBS_IDX_DLY_STILL   3'h1
`define SEBS_IDX_WAIT_RUN    3'h2
`define SEBS_IDX_SPD_RUN     3'h3
`define SEBS_IDX_DLY_REL     3'h4
`define SEBS_IDX_STATUS      3'h5
`define SEBS_IDX_NONE        3'h7
// ----------------------------------------
// reset values and upper limits
// ----------------------------------------
`define SEBS_THR_STILL_DEF   10'h005
`define SEBS_THR_STILL_MAX   16'h03E8
`define SEBS_DLY_STILL_DEF   12'h12C
`define SEBS_DLY_STILL_MAX   16'h07D0
`define SEBS_WAIT_RUN_DEF    12'h1F4
`define SEBS_WAIT_RUN_MAX    16'h07D0
`define SEBS_SPD_RUN_DEF     12'h064
`define SEBS_SPD_RUN_MAX     16'h0BB8
`define SEBS_DLY_REL_DEF     12'h12C
`define SEBS_DLY_REL_MAX     16'h0BB8
// ----------------------------------------
// bus responses
// ----------------------------------------
`define SEBS_RESP_OKAY       2'h0
`define SEBS_RESP_SLVERR     2'h2
`endif

// ==== common/sebs_pkg.sv ====
// types of the servo enable and brake sequencer
// assumes sebs_consts.svh supplies all numeric constants except the state codes below
package sebs_pkg;
   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_BOOT       = 3'h0,
      ST_OFF        = 3'h1,
      ST_REL_WAIT   = 3'h2,
      ST_RUN        = 3'h3,
      ST_STILL_STOP = 3'h4,
      ST_RUN_STOP   = 3'h5
   } sebs_fsm_e;
   // status word layout, high bits first, so fsm sits at the right
   typedef struct packed {
      logic [23:0] rsvd;
      logic        enable_seen;
      logic        alarm_seen;
      logic        ready;
      logic        power;
      logic        brake;
      sebs_fsm_e   fsm;
   } sebs_status_s;
   // whole state of the block
   typedef struct packed {
      sebs_fsm_e   fsm;
      logic [15:0] pre;
      logic [15:0] ms;
      logic        ready;
      logic        power;
      logic        brake;
      logic [9:0]  thr_still;
      logic [11:0] dly_still;
      logic [11:0] wait_run;
      logic [11:0] spd_run;
      logic [11:0] dly_rel;
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sebs_state_s;
endpackage

// ==== logic/sebs_top.sv ====
// servo enable and holding brake sequencer with an AXI4-Lite register slave
// assumes inputs synchronous to aclk and motor_speed as unsigned r/min magnitude
`include "sebs_consts.svh"

module sebs_top #(
   parameter int MS_CYCLES = `SEBS_MS_NS / `SEBS_CLK_NS,  // clock cycles per ms
   parameter int READY_MS  = `SEBS_READY_MS               // power-up wait in ms
) (
   input  logic        aclk,               // system clock
   input  logic        aresetn,            // synchronous reset, low active
   input  logic        servo_enable_in,    // host enable level
   input  logic        alarm_in,           // any drive alarm, high active
   input  logic [15:0] motor_speed,        // speed magnitude, r/min
   output logic        drive_ready,        // drive ready to host
   output logic        power_stage_on,     // power stage on, motor excited
   output logic        brake_release_out,  // relay coil, high releases brake
   input  logic [7:0]  awaddr,             // write address
   input  logic        awvalid,            // write address valid
   output logic        awready,            // write address ready
   input  logic [31:0] wdata,              // write data
   input  logic [3:0]  wstrb,              // write byte strobes
   input  logic        wvalid,             // write data valid
   output logic        wready,             // write data ready
   output logic [1:0]  bresp,              // write response
   output logic        bvalid,             // write response valid
   input  logic        bready,             // write response ready
   input  logic [7:0]  araddr,             // read address
   input  logic        arvalid,            // read address valid
   output logic        arready,            // read address ready
   output logic [31:0] rdata,              // read data
   output logic [1:0]  rresp,              // read response
   output logic        rvalid,             // read data valid
   input  logic        rready              // read data ready
);

   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   if (MS_CYCLES < 1 || MS_CYCLES > 65535 || READY_MS < 0 || READY_MS > 65535) begin : g_chk
      $error("sebs_top: MS_CYCLES or READY_MS out of range");
   end

   localparam logic [15:0] PRE_LAST = 16'(MS_CYCLES - 1);
   localparam logic [15:0] READY_N  = 16'(READY_MS);

   localparam sebs_pkg::sebs_state_s RST = '{
      fsm:       sebs_pkg::ST_BOOT,
      thr_still: `SEBS_THR_STILL_DEF,
      dly_still: `SEBS_DLY_STILL_DEF,
      wait_run:  `SEBS_WAIT_RUN_DEF,
      spd_run:   `SEBS_SPD_RUN_DEF,
      dly_rel:   `SEBS_DLY_REL_DEF,
      default:   '0
   };

   sebs_pkg::sebs_state_s q;
   sebs_pkg::sebs_state_s d;
   sebs_pkg::sebs_status_s stat;
   logic [31:0]            wv;
   logic [2:0]             widx;
   logic                   is_still;
   logic                   run_slow;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // address decode, shared by read and write; unaligned or unmapped gives none
   function automatic logic [2:0] reg_idx(input logic [7:0] a);
      case (a)
         `SEBS_OFS_THR_STILL: reg_idx = `SEBS_IDX_THR_STILL;
         `SEBS_OFS_DLY_STILL: reg_idx = `SEBS_IDX_DLY_STILL;
         `SEBS_OFS_WAIT_RUN:  reg_idx = `SEBS_IDX_WAIT_RUN;
         `SEBS_OFS_SPD_RUN:   reg_idx = `SEBS_IDX_SPD_RUN;
         `SEBS_OFS_DLY_REL:   reg_idx = `SEBS_IDX_DLY_REL;
         `SEBS_OFS_STATUS:    reg_idx = `SEBS_IDX_STATUS;
         default:             reg_idx = `SEBS_IDX_NONE;
      endcase
   endfunction

   // register word by index, used for read data and for strobe merging
   function automatic logic [31:0] reg_word(input logic [2:0] i,
                                            input sebs_pkg::sebs_state_s s,
                                            input logic [31:0] st);
      case (i)
         `SEBS_IDX_THR_STILL: reg_word = {22'h0, s.thr_still};
         `SEBS_IDX_DLY_STILL: reg_word = {20'h0, s.dly_still};
         `SEBS_IDX_WAIT_RUN:  reg_word = {20'h0, s.wait_run};
         `SEBS_IDX_SPD_RUN:   reg_word = {20'h0, s.spd_run};
         `SEBS_IDX_DLY_REL:   reg_word = {20'h0, s.dly_rel};
         `SEBS_IDX_STATUS:    reg_word = st;
         default:             reg_word = 32'h0;
      endcase
   endfunction

   // byte-lane merge under wstrb
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // the low 16 bits of a setting saturate at the top of its range; higher bits are dropped
   function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] mx);
      clip = (v > mx) ? mx : v;
   endfunction

   // ----------------------------------------
   // status view and speed comparisons
   // ----------------------------------------
   assign stat     = '{rsvd: 24'h0, enable_seen: servo_enable_in, alarm_seen: alarm_in,
                       ready: q.ready, power: q.power, brake: q.brake, fsm: q.fsm};
   assign is_still = motor_speed < {6'h0, q.thr_still};
   assign run_slow = motor_speed <= {4'h0, q.spd_run};
   assign widx     = reg_idx(q.awaddr);
   assign wv       = merge(reg_word(widx, q, stat), q.wdata, q.wstrb);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      // ms time base, restarted on every state change below
      if (q.pre >= PRE_LAST) begin
         d.pre = 16'h0;
         if (q.ms != 16'hFFFF) begin
            d.ms = q.ms + 16'h1;
         end
      end else begin
         d.pre = q.pre + 16'h1;
      end

      // sequencer
      case (q.fsm)
         sebs_pkg::ST_BOOT: begin
            if (q.ms >= READY_N) begin
               d.ready = 1'b1;
               d.fsm   = sebs_pkg::ST_OFF;
            end
         end
         sebs_pkg::ST_OFF: begin
            // only reachable with ready set, so enable is ignored before it
            if (servo_enable_in && !alarm_in && q.ready) begin
               d.power = 1'b1;
               d.fsm   = sebs_pkg::ST_REL_WAIT;
            end
         end
         sebs_pkg::ST_REL_WAIT: begin
            if (alarm_in || !servo_enable_in) begin
               d.power = 1'b0;
               d.fsm   = sebs_pkg::ST_OFF;
            end else if ({4'h0, q.ms[11:0]} >= {4'h0, q.dly_rel} || q.ms[15:12] != 4'h0) begin
               d.brake = 1'b1;
               d.fsm   = sebs_pkg::ST_RUN;
            end
         end
         sebs_pkg::ST_RUN: begin
            if (alarm_in || !servo_enable_in) begin
               if (!is_still) begin
                  d.power = 1'b0;
                  d.fsm   = sebs_pkg::ST_RUN_STOP;
               end else if (alarm_in) begin
                  // an alarm allows no holding phase
                  d.power = 1'b0;
                  d.brake = 1'b0;
                  d.fsm   = sebs_pkg::ST_OFF;
               end else begin
                  d.brake = 1'b0;
                  d.fsm   = sebs_pkg::ST_STILL_STOP;
               end
            end
         end
         sebs_pkg::ST_STILL_STOP: begin
            // speed is no longer looked at here
            if (alarm_in || q.ms >= {4'h0, q.dly_still}) begin
               d.power = 1'b0;
               d.fsm   = sebs_pkg::ST_OFF;
            end
         end
         sebs_pkg::ST_RUN_STOP: begin
            if (run_slow || q.ms >= {4'h0, q.wait_run}) begin
               d.brake = 1'b0;
               d.fsm   = sebs_pkg::ST_OFF;
            end
         end
         default: begin
            d.power = 1'b0;
            d.brake = 1'b0;
            d.fsm   = sebs_pkg::ST_OFF;
         end
      endcase
      if (d.fsm != q.fsm) begin
         d.pre = 16'h0;
         d.ms  = 16'h0;
      end

      // write channel: address and data in either order, then one response
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (q.awready && awvalid) begin
         d.aw_got = 1'b1;
         d.awaddr = awaddr;
      end
      if (q.wready && wvalid) begin
         d.w_got = 1'b1;
         d.wdata = wdata;
         d.wstrb = wstrb;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `SEBS_RESP_OKAY;
         case (widx)
            `SEBS_IDX_THR_STILL: d.thr_still = 10'(clip(wv[15:0], `SEBS_THR_STILL_MAX));
            `SEBS_IDX_DLY_STILL: d.dly_still = 12'(clip(wv[15:0], `SEBS_DLY_STILL_MAX));
            `SEBS_IDX_WAIT_RUN:  d.wait_run  = 12'(clip(wv[15:0], `SEBS_WAIT_RUN_MAX));
            `SEBS_IDX_SPD_RUN:   d.spd_run   = 12'(clip(wv[15:0], `SEBS_SPD_RUN_MAX));
            `SEBS_IDX_DLY_REL:   d.dly_rel   = 12'(clip(wv[15:0], `SEBS_DLY_REL_MAX));
            default:             d.bresp     = `SEBS_RESP_SLVERR;
         endcase
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;

      // read channel: one outstanding read, answered the cycle after address
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (q.arready && arvalid) begin
         d.rvalid = 1'b1;
         d.rdata  = reg_word(reg_idx(araddr), q, stat);
         d.rresp  = (reg_idx(araddr) == `SEBS_IDX_NONE) ? `SEBS_RESP_SLVERR
                                                         : `SEBS_RESP_OKAY;
      end
      d.arready = !d.rvalid;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign drive_ready       = q.ready;
   assign power_stage_on    = q.power;
   assign brake_release_out = q.brake;
   assign awready           = q.awready;
   assign wready            = q.wready;
   assign bresp             = q.bresp;
   assign bvalid            = q.bvalid;
   assign arready           = q.arready;
   assign rdata             = q.rdata;
   assign rresp             = q.rresp;
   assign rvalid            = q.rvalid;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_ready_delay: assert property ($rose(drive_ready) |-> $past(q.ms) >= READY_N)
      else $error("ready rose before the power-up wait");
   a_enable_gated: assert property (!drive_ready |-> !power_stage_on)
      else $error("power stage on without drive ready");
   a_enable_start: assert property (
      (q.fsm == sebs_pkg::ST_OFF && servo_enable_in && !alarm_in && drive_ready)
      |=> power_stage_on && !brake_release_out)
      else $error("enable did not switch the power stage on");
   a_alarm_cut: assert property (alarm_in |=> !power_stage_on)
      else $error("power stage still on after alarm");
   a_still_hold: assert property (
      (q.fsm == sebs_pkg::ST_RUN && !servo_enable_in && !alarm_in && is_still)
      |=> power_stage_on && !brake_release_out)
      else $error("slow stop did not hold current with brake applied");
   a_run_cut: assert property (
      (q.fsm == sebs_pkg::ST_RUN && !servo_enable_in && !is_still)
      |=> !power_stage_on && brake_release_out)
      else $error("fast stop did not cut current with brake released");
   a_run_brake: assert property (
      (q.fsm == sebs_pkg::ST_RUN_STOP && run_slow) |=> !brake_release_out)
      else $error("brake not applied once speed fell");
   a_release_order: assert property (
      $rose(brake_release_out) |-> $past(power_stage_on, 1) && power_stage_on)
      else $error("brake released before current was on");
   a_hold_seq: assert property (
      q.fsm == sebs_pkg::ST_STILL_STOP |=> q.fsm inside {sebs_pkg::ST_STILL_STOP,
                                                         sebs_pkg::ST_OFF})
      else $error("slow stop left for another sequence");
   a_brake_off: assert property (!power_stage_on && !$past(power_stage_on)
      && q.fsm != sebs_pkg::ST_RUN_STOP |-> !brake_release_out)
      else $error("brake released with the stage off outside a fast stop");

endmodule // sebs_top

// ==== test/sebs_host_model.sv ====
// host motion controller model that drives the servo enable level
// assumes the bench requests enable through want_on and aclk at 20 MHz
module sebs_host_model (
   input  wire logic aclk,            // system clock
   input  wire logic aresetn,         // synchronous reset, low active
   input  wire logic drive_ready,     // ready level from the drive
   input  wire logic want_on,         // bench asks for enable
   input  wire logic force_early,     // bench asks to skip the ready wait
   output logic      servo_enable_in  // enable level to the drive
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // enable driver
   // ----------------------------------------
   // a real host waits for ready; force_early lets the bench break that on purpose
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         servo_enable_in <= 1'b0;
      end else begin
         servo_enable_in <= want_on && (drive_ready || force_early);
      end
   end
endmodule // sebs_host_model

// ==== test/tb.sv ====
// self-checking bench of the servo enable and brake sequencer
// assumes short timing parameters: 4 cycles per ms, 3 ms power-up wait
`include "sebs_consts.svh"
`define TB_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, want_on, force_early, servo_enable_in, alarm_in;
   logic        drive_ready, power_stage_on, brake_release_out;
   logic [15:0] motor_speed;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          n_fail, total_checks;
   logic [3:0]  wmask;
   logic [7:0]  ofs [5] = '{`SEBS_OFS_THR_STILL, `SEBS_OFS_DLY_STILL, `SEBS_OFS_WAIT_RUN,
                            `SEBS_OFS_SPD_RUN, `SEBS_OFS_DLY_REL};
   logic [31:0] dfl [5] = '{32'h5, 32'h12C, 32'h1F4, 32'h64, 32'h12C};

   sebs_top #(.MS_CYCLES(4), .READY_MS(3)) uut (
      .aclk(aclk), .aresetn(aresetn), .servo_enable_in(servo_enable_in),
      .alarm_in(alarm_in), .motor_speed(motor_speed), .drive_ready(drive_ready),
      .power_stage_on(power_stage_on), .brake_release_out(brake_release_out),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   sebs_host_model host (
      .aclk(aclk), .aresetn(aresetn), .drive_ready(drive_ready), .want_on(want_on),
      .force_early(force_early), .servo_enable_in(servo_enable_in));

   // ----------------------------------------
   // clock, verdict and watchdog
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic finish_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // generous bound; the whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      finish_test();
   end

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   // write: address and data offered together, each dropped once taken
   // no local limit here: a stalled slave is caught by the watchdog
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= wmask;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      `TB_CHK(bresp, er)
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      `TB_CHK({rresp, rdata}, {er, ed})
      rready <= 1'b0;
   endtask

   function automatic logic pick(input int i);
      case (i)
         0: return drive_ready;
         1: return power_stage_on;
         default: return brake_release_out;
      endcase
   endfunction

   // edges until an output reaches v must fall inside [lo, hi]
   task automatic wait_out(input int i, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      while (pick(i) !== v && n <= hi) begin
         @(posedge aclk);
         #1;
         n++;
      end
      `TB_CHK(n >= lo && n <= hi, 1'b1)
   endtask

   task automatic drv(input logic w, input logic [15:0] s, input logic al);
      @(posedge aclk);
      want_on <= w;
      motor_speed <= s;
      alarm_in <= al;
   endtask

   task automatic start_run();
      drv(1'b1, 16'h0000, 1'b0);
      wait_out(1, 1'b1, 2, 3);
      `TB_CHK(brake_release_out, 1'b0)
      wait_out(2, 1'b1, 6, 12);
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      aresetn = 1'b0;
      want_on = 1'b1;
      force_early = 1'b1;
      alarm_in = 1'b0;
      motor_speed = 16'h0000;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wmask = 4'hF;
      n_fail = 0;
      total_checks = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // enable is already high here; the drive must not act on it yet
      repeat (6) @(posedge aclk);
      #1;
      `TB_CHK({drive_ready, power_stage_on, brake_release_out}, 3'h0)
      drv(1'b0, 16'h0000, 1'b0);
      force_early <= 1'b0;
      wait_out(0, 1'b1, 2, 10);
      axr(`SEBS_OFS_STATUS, 32'h21, `SEBS_RESP_OKAY);
      for (int k = 0; k < 5; k++) axr(ofs[k], dfl[k], `SEBS_RESP_OKAY);
      axr(8'h18, 32'h0, `SEBS_RESP_SLVERR);
      axw(8'h02, 32'h1, `SEBS_RESP_SLVERR);
      axw(`SEBS_OFS_STATUS, 32'hFF, `SEBS_RESP_SLVERR);
      axw(`SEBS_OFS_THR_STILL, 32'hFFFF, `SEBS_RESP_OKAY);
      axr(`SEBS_OFS_THR_STILL, 32'h3E8, `SEBS_RESP_OKAY);
      // short delays keep each sequence to a few dozen cycles
      axw(`SEBS_OFS_THR_STILL, 32'd200, `SEBS_RESP_OKAY);
      axw(`SEBS_OFS_DLY_STILL, 32'd2, `SEBS_RESP_OKAY);
      axw(`SEBS_OFS_WAIT_RUN, 32'd3, `SEBS_RESP_OKAY);
      axw(`SEBS_OFS_DLY_REL, 32'd2, `SEBS_RESP_OKAY);
      start_run();
      axr(`SEBS_OFS_STATUS, 32'hBB, `SEBS_RESP_OKAY);
      // just below threshold: hold phase, kept even when speed jumps
      drv(1'b0, 16'd199, 1'b0);
      wait_out(2, 1'b0, 1, 3);
      `TB_CHK(power_stage_on, 1'b1)
      drv(1'b0, 16'd1000, 1'b0);
      wait_out(1, 1'b0, 5, 12);
      // at threshold: running stop, brake held until speed falls
      start_run();
      drv(1'b0, 16'd200, 1'b0);
      wait_out(1, 1'b0, 1, 3);
      repeat (4) begin
         @(posedge aclk);
         #1;
         `TB_CHK(brake_release_out, 1'b1)
      end
      drv(1'b0, 16'd100, 1'b0);
      wait_out(2, 1'b0, 1, 3);
      // running stop ended by the waiting time instead
      start_run();
      drv(1'b0, 16'd3000, 1'b0);
      wait_out(1, 1'b0, 1, 3);
      wait_out(2, 1'b0, 9, 15);
      // alarm with motor still: stage and brake drop together
      start_run();
      drv(1'b1, 16'h0000, 1'b1);
      wait_out(1, 1'b0, 1, 3);
      `TB_CHK(brake_release_out, 1'b0)
      repeat (4) begin
         @(posedge aclk);
         #1;
         `TB_CHK(power_stage_on, 1'b0)
      end
      drv(1'b1, 16'h0000, 1'b0);
      wait_out(1, 1'b1, 1, 4);
      // enable dropped before the brake opens: stage off, brake never released
      drv(1'b0, 16'h0000, 1'b0);
      wait_out(1, 1'b0, 1, 3);
      repeat (12) begin
         @(posedge aclk);
         #1;
         `TB_CHK(brake_release_out, 1'b0)
      end
      // one byte lane written, the other lanes keep the stored value
      wmask = 4'h2;
      axw(`SEBS_OFS_THR_STILL, 32'h00000177, `SEBS_RESP_OKAY);
      axr(`SEBS_OFS_THR_STILL, 32'h1C8, `SEBS_RESP_OKAY);
      finish_test();
   end
endmodule // tb
